// ### rtl/fault_filter.v
// Digital glitch filter built from a clocked counter.
// Assumes its input is already synchronous to clk.
`timescale 1ns/100ps
module fault_filter #(
    parameter LIMIT = 1250,
    parameter WIDTH = 16,
    parameter SYMMETRIC = 0
) (
    input wire clk,
    input wire rst,
    input wire raw,
    output reg filt_q
);
    // Cycles that the input has differed from the output.
    reg [WIDTH-1:0] cnt_q;

    // Asymmetric mode drops at once when the input goes inactive; symmetric
    // mode needs a stable run in both directions.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= {WIDTH{1'b0}};
            filt_q <= 1'b0;
        end
        else if (raw == filt_q)
        begin
            // Input agrees: restart the count.
            cnt_q <= {WIDTH{1'b0}};
        end
        else if (!raw && SYMMETRIC == 0)
        begin
            // Fault gone: clear without delay.
            cnt_q <= {WIDTH{1'b0}};
            filt_q <= 1'b0;
        end
        else if (cnt_q == LIMIT[WIDTH-1:0] - 1'b1)
        begin
            // Count reached its limit: take the new level.
            cnt_q <= {WIDTH{1'b0}};
            filt_q <= raw;
        end
        else
        begin
            // Still counting.
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // fault_filter

// ### rtl/supply_fault_safety_monitor.v
// Supply fault and safety monitor for a seven-channel gate pre-driver.
// Assumes asynchronous comparator and pin inputs; serial errors on clk.
//
// Overview of operation
// - Test currents only in normal mode without faults.
// - Pump low sets flag after filter time.
// - Pump fail latches all gates off, flags.
// - Over-voltage masks the pump fail flag.
// - Over-voltage latches high gates off only.
// - Over-voltage reduces high pull-down, registers kept.
// - Over-voltage kills test currents with no delay.
// - Over-voltage sets the over-voltage flag.
// - Mid over-voltage keeps pump, high gates off.
// - Above pump limit, pump off and discharged.
// - Under-voltage disables all gates, sets flag.
// - Under-voltage keeps pump and switched output.
// - Logic power-on reset enters sleep at once.
// - Every logic pin passes a digital filter.
// - Serial error enters failsafe immediately.
// - Communication ok bit in every response.
// - Switch status follows driver; PWM reads both.
// - Nominal supply permits full PWM operation.
// - Pump fail flag one when latched, no over-voltage.
`timescale 1ns/100ps
`include "supply_monitor_defines.vh"
module supply_fault_safety_monitor #(
    parameter CHANNELS = 7,
    parameter TEST_CH = 3,
    parameter PUMP_LOW_CYC = `PUMP_LOW_FILTER_CYC,
    parameter PUMP_FAIL_CYC = `PUMP_FAIL_FILTER_CYC,
    parameter OVERVOLT_CYC = `OVERVOLT_FILTER_CYC,
    parameter UNDERVOLT_CYC = `UNDERVOLT_FILTER_CYC,
    parameter PIN_CYC = `PIN_FILTER_CYC
) (
    input wire clk,
    input wire rst,
    input wire pump_low_cmp,
    input wire pump_fail_cmp,
    input wire overvolt_cmp,
    input wire pump_overvolt_cmp,
    input wire undervolt_cmp,
    input wire logic_por,
    input wire wake_pin,
    input wire failsafe_pin,
    input wire [CHANNELS-1:0] pwm_pin,
    input wire toggle_err,
    input wire protocol_err,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    output reg [CHANNELS-1:0] high_gate_out,
    output reg [CHANNELS-1:0] low_gate_out,
    output reg [TEST_CH-1:0] high_test_current_en,
    output reg [TEST_CH-1:0] low_test_current_en,
    output reg high_pulldown_reduced,
    output reg pump_enable,
    output reg switched_pump_out,
    output reg pump_discharge,
    output reg comm_ok_bit
);
    // One-hot operating modes.
    localparam [2:0] MODE_SLEEP = 3'b001;
    localparam [2:0] MODE_NORMAL = 3'b010;
    localparam [2:0] MODE_FAILSAFE = 3'b100;

    // Width of the pin vector that is synchronised.
    localparam NPIN = CHANNELS + 8;

    // Raw pins gathered for the synchroniser.
    wire [NPIN-1:0] pin_raw;
    // First and second synchroniser stages.
    reg [NPIN-1:0] sync1_q, sync2_q;
    // Filtered supply faults.
    wire pump_low_dg, pump_fail_dg, overvolt_dg, undervolt_dg;
    // Filtered logic pins.
    wire wake_dg, failsafe_dg;
    wire [CHANNELS-1:0] pwm_dg;
    // Synchronised levels used without filtering.
    wire overvolt_now, pump_ov_now, por_now;

    // Operating mode and its next value.
    reg [2:0] mode_q, mode_d;
    // Latched global faults.
    reg pump_fail_lat_q, overvolt_lat_q, undervolt_lat_q;
    // Sticky pump-low flag and serial failure flag.
    reg pump_low_flag_q, comm_fail_q;
    // Software registers.
    reg [CHANNELS-1:0] hb_enable_q, hb_polarity_q, hb_pwm_sel_q;
    reg [5:0] diag_control_reg_q;

    // Decoded strobes.
    wire wr_ctrl, restart, comm_err;
    // Flags as seen by software.
    wire pump_fail_flag, overvolt_fail_flag, undervolt_fail_flag;
    wire pump_low_flag;
    // Gate permissions, test current permission and drive demand.
    wire low_allowed, high_allowed, test_ok;
    wire [CHANNELS-1:0] high_demand, low_demand;
    // Status words.
    wire [15:0] device_status_reg, switch_status_reg;
    reg [15:0] rdata_d;

    assign pin_raw = {pwm_pin, failsafe_pin, wake_pin, logic_por,
                      pump_overvolt_cmp, undervolt_cmp, overvolt_cmp,
                      pump_fail_cmp, pump_low_cmp};

    // Two flip-flops on every pin before any logic reads it.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= {NPIN{1'b0}};
            sync2_q <= {NPIN{1'b0}};
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    assign overvolt_now = sync2_q[2];
    assign pump_ov_now = sync2_q[4];
    assign por_now = sync2_q[5];

    // Supply filters drop at once when the comparator releases.
    fault_filter #(.LIMIT(PUMP_LOW_CYC), .SYMMETRIC(0))
    u_pump_low (.clk(clk), .rst(rst), .raw(sync2_q[0]),
                .filt_q(pump_low_dg));
    fault_filter #(.LIMIT(PUMP_FAIL_CYC), .SYMMETRIC(0))
    u_pump_fail (.clk(clk), .rst(rst), .raw(sync2_q[1]),
                 .filt_q(pump_fail_dg));
    fault_filter #(.LIMIT(OVERVOLT_CYC), .SYMMETRIC(0))
    u_overvolt (.clk(clk), .rst(rst), .raw(sync2_q[2]),
                .filt_q(overvolt_dg));
    fault_filter #(.LIMIT(UNDERVOLT_CYC), .SYMMETRIC(0))
    u_undervolt (.clk(clk), .rst(rst), .raw(sync2_q[3]),
                 .filt_q(undervolt_dg));

    // Logic pins use a symmetric filter, one per pin.
    fault_filter #(.LIMIT(PIN_CYC), .SYMMETRIC(1))
    u_wake (.clk(clk), .rst(rst), .raw(sync2_q[6]),
            .filt_q(wake_dg));
    fault_filter #(.LIMIT(PIN_CYC), .SYMMETRIC(1))
    u_fspin (.clk(clk), .rst(rst), .raw(sync2_q[7]),
             .filt_q(failsafe_dg));

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1)
        begin : g_pwm
            // One filter for each PWM input pin.
            fault_filter #(.LIMIT(PIN_CYC), .SYMMETRIC(1))
            u_pwm (.clk(clk), .rst(rst), .raw(sync2_q[8+gi]),
                   .filt_q(pwm_dg[gi]));
        end
    endgenerate

    // Strobe decode and serial error detection.
    assign wr_ctrl = wr && (addr == `REG_MODE_CTRL);
    assign restart = wr_ctrl && wdata[`CTRL_RESTART];
    assign comm_err = toggle_err || protocol_err;

    // Mode sequencing: power-on reset wins, then serial errors.
    always @*
    begin
        mode_d = mode_q;
        // Logic supply lost: sleep without delay.
        if (por_now)
            mode_d = MODE_SLEEP;
        else
            case (mode_q)
                MODE_SLEEP:
                    // Only a wake-up leaves sleep.
                    if (wake_dg)
                        mode_d = MODE_NORMAL;
                MODE_NORMAL:
                    // Serial error, pin or software command.
                    if (comm_err)
                        mode_d = MODE_FAILSAFE;
                    else if (failsafe_dg ||
                             (wr_ctrl && wdata[`CTRL_GO_FAILSAFE]))
                        mode_d = MODE_FAILSAFE;
                MODE_FAILSAFE:
                    // Return to normal on command once the pin is low.
                    if (wr_ctrl && wdata[`CTRL_GO_NORMAL] &&
                        !failsafe_dg && !comm_err)
                        mode_d = MODE_NORMAL;
                default:
                    mode_d = MODE_SLEEP;
            endcase
    end

    // Mode register and fault latches; a new fault wins over a restart.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= MODE_SLEEP;
            pump_fail_lat_q <= 1'b0;
            overvolt_lat_q <= 1'b0;
            undervolt_lat_q <= 1'b0;
            pump_low_flag_q <= 1'b0;
            comm_fail_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            // Pump fail latches every gate off.
            pump_fail_lat_q <= pump_fail_dg ||
                (pump_fail_lat_q && !restart);
            // Over-voltage latches the high gates off.
            overvolt_lat_q <= overvolt_dg ||
                (overvolt_lat_q && !restart);
            // Under-voltage latches all gates off.
            undervolt_lat_q <= undervolt_dg ||
                (undervolt_lat_q && !restart);
            // Pump-low flag after its filter time.
            pump_low_flag_q <= pump_low_dg ||
                (pump_low_flag_q && !restart);
            // Serial failure stays until a go-normal command with no serial error.
            comm_fail_q <= comm_err || (comm_fail_q &&
                !(wr_ctrl && wdata[`CTRL_GO_NORMAL]));
        end
    end

    // Flags: pump fail is masked while over the rising threshold.
    assign pump_fail_flag = pump_fail_lat_q &&
        !overvolt_now;
    assign overvolt_fail_flag = overvolt_lat_q;
    assign undervolt_fail_flag = undervolt_lat_q;
    assign pump_low_flag = pump_low_flag_q;

    // Gate permissions; low side survives over-voltage for braking.
    assign low_allowed = mode_q[1] && !pump_fail_lat_q &&
        !undervolt_lat_q;
    assign high_allowed = low_allowed && !overvolt_lat_q;
    assign test_ok = high_allowed && !overvolt_now && !pump_fail_dg &&
        !undervolt_dg;

    // Drive demand: PWM channels follow the filtered pin, others polarity.
    assign high_demand = hb_enable_q &
        ((hb_pwm_sel_q & pwm_dg) | (~hb_pwm_sel_q & hb_polarity_q));
    assign low_demand = hb_enable_q &
        ((hb_pwm_sel_q & ~pwm_dg) | (~hb_pwm_sel_q & ~hb_polarity_q));

    // Software registers; action bits of the control word are not stored.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hb_enable_q <= `RST_HB;
            hb_polarity_q <= `RST_HB;
            hb_pwm_sel_q <= `RST_HB;
            diag_control_reg_q <= `RST_DIAG;
        end
        else if (wr)
        begin
            // Write decode by register index.
            case (addr)
                `REG_HB_ENABLE: hb_enable_q <= wdata[CHANNELS-1:0];
                `REG_HB_POLARITY: hb_polarity_q <= wdata[CHANNELS-1:0];
                `REG_HB_PWM_SEL: hb_pwm_sel_q <= wdata[CHANNELS-1:0];
                `REG_DIAG_CTRL: diag_control_reg_q <= wdata[5:0];
                default: hb_enable_q <= hb_enable_q; // Stores nothing.
            endcase
        end
    end

    // Registered outputs toward the analog front end.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            high_gate_out <= {CHANNELS{1'b0}};
            low_gate_out <= {CHANNELS{1'b0}};
            high_test_current_en <= {TEST_CH{1'b0}};
            low_test_current_en <= {TEST_CH{1'b0}};
            high_pulldown_reduced <= 1'b0;
            pump_enable <= 1'b0;
            switched_pump_out <= 1'b0;
            pump_discharge <= 1'b0;
        end
        else
        begin
            // High gates need the stricter permission.
            high_gate_out <= high_allowed ?
                high_demand : {CHANNELS{1'b0}};
            low_gate_out <= low_allowed ?
                low_demand : {CHANNELS{1'b0}};
            // Test currents: normal mode, no global fault, no over-voltage.
            high_test_current_en <= test_ok ? {diag_control_reg_q[5],
                diag_control_reg_q[3], diag_control_reg_q[1]} :
                {TEST_CH{1'b0}};
            low_test_current_en <= test_ok ? {diag_control_reg_q[4],
                diag_control_reg_q[2], diag_control_reg_q[0]} :
                {TEST_CH{1'b0}};
            // Weak pull-down during over-voltage; settings untouched.
            high_pulldown_reduced <= overvolt_now;
            // Pump runs outside sleep and below the pump limit, even under other faults.
            pump_enable <= !mode_q[0] &&
                !pump_ov_now;
            switched_pump_out <= !mode_q[0] &&
                !pump_ov_now;
            // Above the pump limit the buffer is discharged.
            pump_discharge <= pump_ov_now;
        end
    end

    // Status words returned to software.
    assign device_status_reg = {8'h00, mode_q[1], mode_q[0], mode_q[2],
        comm_fail_q, pump_low_flag, pump_fail_flag,
        undervolt_fail_flag, overvolt_fail_flag};
    // Switch status follows the driver; PWM channels read both set.
    assign switch_status_reg = {2'b00,
        high_gate_out | hb_pwm_sel_q,
        low_gate_out | hb_pwm_sel_q};

    // Read mux; unmapped indices read zero, bit 15 carries comm ok.
    always @*
    begin
        case (addr)
            `REG_HB_ENABLE: rdata_d = {9'h000, hb_enable_q};
            `REG_HB_POLARITY: rdata_d = {9'h000, hb_polarity_q};
            `REG_HB_PWM_SEL: rdata_d = {9'h000, hb_pwm_sel_q};
            `REG_DIAG_CTRL: rdata_d = {10'h000, diag_control_reg_q};
            `REG_DEV_STATUS: rdata_d = device_status_reg;
            `REG_SW_STATUS: rdata_d = switch_status_reg;
            default: rdata_d = 16'h0000;
        endcase
        rdata_d[`COMM_OK_BIT] = mode_q[1] && !comm_fail_q;
    end

    // Read data stands one cycle after the strobe and only then.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
            comm_ok_bit <= 1'b0;
        end
        else
        begin
            rdata <= rd ? rdata_d : 16'h0000;
            comm_ok_bit <= mode_q[1] && !comm_fail_q;
        end
    end
endmodule // supply_fault_safety_monitor

// ### rtl/supply_monitor_defines.vh
// Constants for the supply fault and safety monitor: register indices,
// field positions, reset values, filter times and derived cycle counts.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef SUPPLY_MONITOR_DEFINES_VH
`define SUPPLY_MONITOR_DEFINES_VH

// Core clock period in nanoseconds.
`define CLK_PERIOD_NS 8

// Filter times in nanoseconds.
`define PUMP_LOW_FILTER_NS 10000
`define PUMP_FAIL_FILTER_NS 10000
`define OVERVOLT_FILTER_NS 10000
`define UNDERVOLT_FILTER_NS 10000
`define PIN_FILTER_NS 1000

// Least times round up to whole cycles.
`define NS_TO_CYC(ns) ((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PUMP_LOW_FILTER_CYC `NS_TO_CYC(`PUMP_LOW_FILTER_NS)
`define PUMP_FAIL_FILTER_CYC `NS_TO_CYC(`PUMP_FAIL_FILTER_NS)
`define OVERVOLT_FILTER_CYC `NS_TO_CYC(`OVERVOLT_FILTER_NS)
`define UNDERVOLT_FILTER_CYC `NS_TO_CYC(`UNDERVOLT_FILTER_NS)
`define PIN_FILTER_CYC `NS_TO_CYC(`PIN_FILTER_NS)

// Register indices on the plain register port.
`define REG_MODE_CTRL 4'h0
`define REG_HB_ENABLE 4'h1
`define REG_HB_POLARITY 4'h2
`define REG_HB_PWM_SEL 4'h3
`define REG_DIAG_CTRL 4'h4
`define REG_DEV_STATUS 4'h5
`define REG_SW_STATUS 4'h6

// Mode control action bits.
`define CTRL_GO_NORMAL 0
`define CTRL_GO_FAILSAFE 1
`define CTRL_RESTART 2

// Device status fields.
`define ST_OVERVOLT 0
`define ST_UNDERVOLT 1
`define ST_PUMP_FAIL 2
`define ST_PUMP_LOW 3
`define ST_COMM_FAIL 4
`define ST_FAILSAFE 5
`define ST_SLEEP 6
`define ST_NORMAL 7
`define COMM_OK_BIT 15

// Reset values.
`define RST_HB 7'h00
`define RST_DIAG 6'h00

`endif

// ### sim/host_model.sv
// Host side model: one-cycle strobes on the plain register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
module host_model (
    input wire clk,
    output reg [3:0] addr,
    output reg [15:0] wdata,
    output reg wr,
    output reg rd,
    input wire [15:0] rdata
);
    // Bus idles with both strobes low from time zero.
    initial
        {addr, wdata, wr, rd} = 22'h00_0000;

    // One write cycle; a later call starts one edge on, so strobes part.
    task wr_reg(input [3:0] a, input [15:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask

    // One read cycle; the word is taken at the edge that ends its cycle.
    task rd_reg(input [3:0] a, output [15:0] d);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    end
    endtask

    // Compare switch status; on a mismatch force failsafe, then normal.
    // The bench keeps PWM quiet, so no duty cut is needed.
    task sw_verify(input [15:0] want);
        reg [15:0] got;
    begin
        rd_reg(4'h6, got);
        if (got !== want)
        begin
            wr_reg(4'h0, 16'h0002);
            wr_reg(4'h0, 16'h0001);
        end
    end
    endtask
endmodule // host_model

// ### sim/supply_monitor_asserts.sv
// Checker for the supply fault monitor: supply faults, serial errors,
// power-on entry and read framing. Bound to the top module by name.
`timescale 1ns/100ps
module supply_monitor_asserts #(
    parameter CHANNELS = 7,
    parameter TEST_CH = 3,
    parameter PUMP_FAIL_CYC = 4,
    parameter OVERVOLT_CYC = 4,
    parameter UNDERVOLT_CYC = 4
) (
    input wire clk,
    input wire rst,
    input wire pump_fail_cmp,
    input wire overvolt_cmp,
    input wire pump_overvolt_cmp,
    input wire undervolt_cmp,
    input wire logic_por,
    input wire toggle_err,
    input wire protocol_err,
    input wire rd,
    input wire [15:0] rdata,
    input wire [CHANNELS-1:0] high_gate_out,
    input wire [CHANNELS-1:0] low_gate_out,
    input wire [TEST_CH-1:0] high_test_current_en,
    input wire [TEST_CH-1:0] low_test_current_en,
    input wire high_pulldown_reduced,
    input wire pump_enable,
    input wire pump_discharge,
    input wire comm_ok_bit
);
    // Consecutive high cycles of the over-voltage, under-voltage and pump fail comparators; a low cycle restarts each.
    reg [15:0] ov_run_q;
    reg [15:0] uv_run_q;
    reg [15:0] pf_run_q;

    // Run counters shadow the filters with a margin for the sync stages.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ov_run_q <= 16'h0000;
            uv_run_q <= 16'h0000;
            pf_run_q <= 16'h0000;
        end
        else
        begin
            ov_run_q <= overvolt_cmp ? ov_run_q + 16'h0001 : 16'h0000;
            uv_run_q <= undervolt_cmp ? uv_run_q + 16'h0001 : 16'h0000;
            pf_run_q <= pump_fail_cmp ? pf_run_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_ov_pulldown: assert property (
        $rose(overvolt_cmp) |-> ##4 high_pulldown_reduced)
        else $error("pull-down not reduced on over-voltage");
    chk_ov_tests_off: assert property (
        $rose(overvolt_cmp) |-> ##4
        (high_test_current_en == 0 && low_test_current_en == 0))
        else $error("test currents still on in over-voltage");
    chk_ov_high_off: assert property (
        ov_run_q > OVERVOLT_CYC + 5 |-> high_gate_out == 0)
        else $error("high gates on after over-voltage filter");
    chk_uv_gates_off: assert property (
        uv_run_q > UNDERVOLT_CYC + 5 |->
        (high_gate_out == 0 && low_gate_out == 0))
        else $error("gates on after under-voltage filter");
    chk_pf_all_off: assert property (
        pf_run_q > PUMP_FAIL_CYC + 5 |-> (high_gate_out == 0 &&
        low_gate_out == 0 && high_test_current_en == 0))
        else $error("outputs on after pump fail filter");
    chk_uv_pump_kept: assert property (
        (uv_run_q > UNDERVOLT_CYC + 5) && pump_enable |=> pump_enable)
        else $error("pump stopped during under-voltage");
    chk_pump_limit: assert property (
        pump_overvolt_cmp [*4] |-> !pump_enable && pump_discharge)
        else $error("pump not off and discharged above limit");
    chk_serial_fs: assert property (
        (toggle_err || protocol_err) |-> ##3
        (!comm_ok_bit && high_gate_out == 0 && low_gate_out == 0))
        else $error("no failsafe after serial error");
    chk_por_sleep: assert property (
        logic_por |-> ##5 (!comm_ok_bit && high_gate_out == 0))
        else $error("no sleep after logic power-on reset");
    chk_read_comm: assert property (
        $past(rd) |-> rdata[15] == $past(comm_ok_bit))
        else $error("read word lacks communication ok bit");
endmodule // supply_monitor_asserts

bind supply_fault_safety_monitor supply_monitor_asserts #(
    .CHANNELS(CHANNELS), .TEST_CH(TEST_CH),
    .PUMP_FAIL_CYC(PUMP_FAIL_CYC), .OVERVOLT_CYC(OVERVOLT_CYC),
    .UNDERVOLT_CYC(UNDERVOLT_CYC)
) chk_u (.clk, .rst, .pump_fail_cmp, .overvolt_cmp, .pump_overvolt_cmp,
    .undervolt_cmp, .logic_por, .toggle_err, .protocol_err, .rd, .rdata,
    .high_gate_out, .low_gate_out, .high_test_current_en,
    .low_test_current_en, .high_pulldown_reduced, .pump_enable,
    .pump_discharge, .comm_ok_bit);

// ### sim/testbench.sv
// Self-checking bench for the supply fault monitor with small filters.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module testbench;
    reg clk, rst, pump_low_cmp, pump_fail_cmp, overvolt_cmp;
    reg pump_overvolt_cmp, undervolt_cmp, logic_por, wake_pin;
    reg failsafe_pin, toggle_err, protocol_err;
    reg [6:0] pwm_pin;
    wire [3:0] addr;
    wire [15:0] wdata, rdata;
    wire wr, rd, high_pulldown_reduced, pump_enable;
    wire switched_pump_out, pump_discharge, comm_ok_bit;
    wire [6:0] high_gate_out, low_gate_out;
    wire [2:0] high_test_current_en, low_test_current_en;
    integer errors, n_tests, i;
    reg [15:0] st;

    supply_fault_safety_monitor #(.PUMP_LOW_CYC(4), .PUMP_FAIL_CYC(4),
        .OVERVOLT_CYC(4), .UNDERVOLT_CYC(4), .PIN_CYC(4)) dut_u (.clk, .rst,
        .pump_low_cmp, .pump_fail_cmp, .overvolt_cmp, .pump_overvolt_cmp,
        .undervolt_cmp, .logic_por, .wake_pin, .failsafe_pin, .pwm_pin,
        .toggle_err, .protocol_err, .addr, .wdata, .wr, .rd, .rdata,
        .high_gate_out, .low_gate_out, .high_test_current_en,
        .low_test_current_en, .high_pulldown_reduced, .pump_enable,
        .switched_pump_out, .pump_discharge, .comm_ok_bit);
    host_model host_u (.clk, .addr, .wdata, .wr, .rd, .rdata);

    // 125 MHz core clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task chk(input [8*8:1] what, input [15:0] seen, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
        end
    end
    endtask

    task wait_n(input integer n);
        repeat (n) @(posedge clk);
    endtask

    // Reads device status and compares the bits under the mask.
    task stat(input [15:0] m, input [15:0] e);
    begin
        host_u.rd_reg(4'h5, st);
        chk("status", st & m, e);
    end
    endtask

    task final_report;
    begin
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    // Watchdog: far beyond the some 320 cycles the tests need.
    initial
    begin
        #200000;
        errors = errors + 1;
        final_report;
    end

    initial
    begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        {pump_low_cmp, pump_fail_cmp, overvolt_cmp, pump_overvolt_cmp,
            undervolt_cmp, logic_por, wake_pin, failsafe_pin, toggle_err,
            protocol_err, pwm_pin} = 17'h0_0000;
        wait_n(6);
        rst <= 1'b0;
        stat(16'hFFFF, 16'h0040);
        wake_pin <= 1'b1;
        wait_n(12);
        stat(16'hFFFF, 16'h8080);
        host_u.wr_reg(4'h1, 16'h007F);
        host_u.wr_reg(4'h2, 16'h0055);
        wait_n(3);
        chk("high", high_gate_out, 16'h0055);
        chk("low", low_gate_out, 16'h002A);
        host_u.rd_reg(4'h6, st);
        chk("switch", st, 16'hAAAA);
        host_u.wr_reg(4'h3, 16'h0001);
        host_u.rd_reg(4'h6, st);
        chk("switch", st, 16'hAAAB);
        chk("high", high_gate_out, 16'h0054);
        pwm_pin <= 7'h01;
        wait_n(10);
        chk("high", high_gate_out, 16'h0055);
        host_u.wr_reg(4'h3, 16'h0000);
        host_u.wr_reg(4'h4, 16'h0029);
        wait_n(3);
        chk("tst_hi", high_test_current_en, 16'h0006);
        chk("tst_lo", low_test_current_en, 16'h0001);
        overvolt_cmp <= 1'b1;
        wait_n(5);
        chk("tst_hi", high_test_current_en, 16'h0000);
        chk("pulldn", high_pulldown_reduced, 16'h0001);
        chk("high", high_gate_out, 16'h0055);
        wait_n(10);
        chk("high", high_gate_out, 16'h0000);
        chk("low", low_gate_out, 16'h002A);
        stat(16'h0001, 16'h0001);
        pump_fail_cmp <= 1'b1;
        wait_n(12);
        stat(16'h0004, 16'h0000);
        chk("low", low_gate_out, 16'h0000);
        overvolt_cmp <= 1'b0;
        wait_n(12);
        stat(16'h0005, 16'h0005);
        chk("pulldn", high_pulldown_reduced, 16'h0000);
        pump_fail_cmp <= 1'b0;
        wait_n(4);
        host_u.wr_reg(4'h0, 16'h0004);
        wait_n(4);
        stat(16'h000F, 16'h0000);
        chk("high", high_gate_out, 16'h0055);
        chk("tst_hi", high_test_current_en, 16'h0006);
        chk("pump", pump_enable, 16'h0001);
        pump_overvolt_cmp <= 1'b1;
        wait_n(6);
        chk("pump", pump_enable, 16'h0000);
        chk("dischg", pump_discharge, 16'h0001);
        pump_overvolt_cmp <= 1'b0;
        wait_n(6);
        chk("pump", pump_enable, 16'h0001);
        undervolt_cmp <= 1'b1;
        wait_n(12);
        chk("low", low_gate_out, 16'h0000);
        chk("high", high_gate_out, 16'h0000);
        chk("pump", pump_enable, 16'h0001);
        chk("pumpsw", switched_pump_out, 16'h0001);
        stat(16'h0002, 16'h0002);
        undervolt_cmp <= 1'b0;
        wait_n(4);
        host_u.wr_reg(4'h0, 16'h0004);
        pump_low_cmp <= 1'b1;
        wait_n(3);
        pump_low_cmp <= 1'b0;
        wait_n(10);
        stat(16'h0008, 16'h0000);
        pump_low_cmp <= 1'b1;
        wait_n(12);
        stat(16'h0008, 16'h0008);
        chk("high", high_gate_out, 16'h0055);
        pump_low_cmp <= 1'b0;
        wait_n(4);
        host_u.wr_reg(4'h0, 16'h0004);
        for (i = 0; i < 2; i = i + 1)
        begin
            toggle_err <= (i == 0);
            protocol_err <= (i == 1);
            wait_n(1);
            toggle_err <= 1'b0;
            protocol_err <= 1'b0;
            wait_n(3);
            chk("comm_ok", comm_ok_bit, 16'h0000);
            chk("high", high_gate_out, 16'h0000);
            stat(16'h0030, 16'h0030);
            host_u.wr_reg(4'h0, 16'h0004);
            host_u.wr_reg(4'h0, 16'h0001);
            wait_n(3);
            chk("comm_ok", comm_ok_bit, 16'h0001);
        end
        failsafe_pin <= 1'b1;
        wait_n(2);
        failsafe_pin <= 1'b0;
        wait_n(10);
        chk("comm_ok", comm_ok_bit, 16'h0001);
        failsafe_pin <= 1'b1;
        wait_n(12);
        stat(16'h0020, 16'h0020);
        failsafe_pin <= 1'b0;
        wait_n(8);
        host_u.wr_reg(4'h0, 16'h0001);
        host_u.sw_verify(16'h0000);
        wait_n(3);
        chk("comm_ok", comm_ok_bit, 16'h0001);
        wake_pin <= 1'b0;
        wait_n(10);
        logic_por <= 1'b1;
        wait_n(6);
        chk("comm_ok", comm_ok_bit, 16'h0000);
        logic_por <= 1'b0;
        wait_n(20);
        stat(16'h00C0, 16'h0040);
        wake_pin <= 1'b1;
        wait_n(12);
        stat(16'h00C0, 16'h0080);
        host_u.rd_reg(4'hF, st);
        chk("unmapped", st & 16'h7FFF, 16'h0000);
        final_report;
    end
endmodule // testbench
